// File: rtl/relay_pkg.sv
// Constants and types shared by the latch and toggle relay elements.
// Assumes a single clock whose edges are the scan cycles of the program.
`default_nettype none
package relay_pkg;

    // ========================================================================
    // Configuration encodings
    // ========================================================================
    typedef enum logic {
        reset_dominant = 1'h0,
        set_dominant   = 1'h1
    } priority_t;

    // Output value with no retained state available.
    localparam logic OUT_INIT   = 1'h0;
    localparam logic OUT_ON     = 1'h1;
    // Level of a program input that is not asserted, seeding the edge history.
    localparam logic IN_IDLE    = 1'h0;
    // Retention disabled, the configuration that reset leaves behind.
    localparam logic RETAIN_OFF = 1'h0;

endpackage
`default_nettype wire

// File: rtl/toggle_relay.sv
// Toggle relay element: trigger edge flips the output, set and reset force it.
// Assumes all inputs are program signals already on the scan clock.
`timescale 1ns/10ps
`default_nettype none
module toggle_relay
    import relay_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      arst_n,
    input  wire logic      set_in,
    input  wire logic      reset_in,
    input  wire logic      trigger_in,
    input  wire priority_t prio_cfg,
    input  wire logic      retain_cfg,
    input  wire logic      retained_q,
    input  wire logic      restore_pulse,
    output logic           q
);

    // ========================================================================
    // State
    // ========================================================================
    logic q_ff;
    logic nxt_q;
    logic trg_prev_ff;
    logic nxt_trg_prev;
    logic trg_rise;

    // Rising edge from this scan's sample against the previous one.
    assign trg_rise = trigger_in & ~trg_prev_ff;

    always_comb begin
        nxt_trg_prev = trigger_in;
        nxt_q        = q_ff;
        if (restore_pulse) begin
            nxt_q = retain_cfg ? retained_q : OUT_INIT;
        end else if (set_in && reset_in) begin
            nxt_q = (prio_cfg == set_dominant) ? OUT_ON : OUT_INIT;
        end else if (reset_in) begin
            nxt_q = OUT_INIT;
        end else if (set_in) begin
            nxt_q = OUT_ON;
        end else if (trg_rise) begin
            nxt_q = ~q_ff;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            q_ff        <= OUT_INIT;
            trg_prev_ff <= IN_IDLE;
        end else begin
            q_ff        <= nxt_q;
            trg_prev_ff <= nxt_trg_prev;
        end
    end

    assign q = q_ff;

    // ========================================================================
    // Checks
    // ========================================================================
    toggle_flip_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!restore_pulse && !set_in && !reset_in && trigger_in && !trg_prev_ff)
        |=> (q_ff != $past(q_ff)))
        else $error("Toggle did not flip on trigger edge.");
    toggle_blocked_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!restore_pulse && (set_in || reset_in)) |=> (q_ff == ($past(set_in) &&
        ($past(prio_cfg) == set_dominant || !$past(reset_in)))))
        else $error("Trigger acted while a forcing input was high.");
    toggle_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!restore_pulse && set_in && !reset_in) |=> q_ff)
        else $error("Set did not force output high.");
    toggle_reset_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!restore_pulse && reset_in && !set_in) |=> !q_ff)
        else $error("Reset did not force output low.");
    toggle_prio_a: assert property (@(posedge clock) disable iff (!arst_n)
        (!restore_pulse && set_in && reset_in) |=> (q_ff == (prio_cfg == set_dominant)))
        else $error("Priority selection not honoured.");
    toggle_restore_a: assert property (@(posedge clock) disable iff (!arst_n)
        (restore_pulse && retain_cfg) |=> (q_ff == $past(retained_q)))
        else $error("Retained state not restored.");

endmodule
`default_nettype wire

// File: rtl/latch_and_toggle_relay.sv
// Latch element and toggle relay element evaluated once per scan clock.
// Assumes inputs come from program logic on the same clock; configuration may
// change at any time, as it is frozen here while running, and the retained
// output values are provided from non-volatile storage at restore.
//
// Contract
// - The latch output goes high when set is high and reset is low.
// - With set and reset both high the latch output goes low.
// - Once set the latch holds high with idle inputs and only reset clears it.
// - With retention on, the latch restores its pre-power-loss output.
// - Configuration is fixed while running and cannot change at runtime.
// - The toggle output inverts on each trigger rising edge when set and reset are low.
// - Trigger edges are ignored while set or reset is high.
// - A set pulse forces the toggle output to one.
// - A reset pulse returns the toggle output to zero.
// - A priority choice selects whether reset or set wins when both are high.
// - With retention on, the toggle output is restored after power returns.
`timescale 1ns/10ps
`default_nettype none
module latch_and_toggle_relay
    import relay_pkg::*;
(
    input  wire logic      clock,
    input  wire logic      arst_n,
    input  wire logic      running,
    input  wire logic      latch_set,
    input  wire logic      latch_reset,
    input  wire logic      latch_retain,
    input  wire logic      latch_saved_q,
    input  wire logic      toggle_set,
    input  wire logic      toggle_reset,
    input  wire logic      toggle_trigger,
    input  wire priority_t toggle_priority,
    input  wire logic      toggle_retain,
    input  wire logic      toggle_saved_q,
    output logic           latch_q,
    output logic           toggle_q
);

    // ========================================================================
    // Configuration capture
    // ========================================================================
    // Settings are captured while stopped and frozen while running, so a
    // change made during runtime has no effect until the next start.
    logic      run_prev_ff;
    logic      nxt_run_prev;
    logic      start_pulse;
    priority_t prio_ff;
    priority_t nxt_prio;
    logic      lret_ff;
    logic      nxt_lret;
    logic      tret_ff;
    logic      nxt_tret;
    logic      latch_ff;
    logic      nxt_latch;

    assign start_pulse = running & ~run_prev_ff;

    always_comb begin
        nxt_run_prev = running;
        nxt_prio     = prio_ff;
        nxt_lret     = lret_ff;
        nxt_tret     = tret_ff;
        if (!running) begin
            nxt_prio = toggle_priority;
            nxt_lret = latch_retain;
            nxt_tret = toggle_retain;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            run_prev_ff <= IN_IDLE;
            prio_ff     <= reset_dominant;
            lret_ff     <= RETAIN_OFF;
            tret_ff     <= RETAIN_OFF;
        end else begin
            run_prev_ff <= nxt_run_prev;
            prio_ff     <= nxt_prio;
            lret_ff     <= nxt_lret;
            tret_ff     <= nxt_tret;
        end
    end

    // ========================================================================
    // Latch element
    // ========================================================================
    always_comb begin
        nxt_latch = latch_ff;
        if (start_pulse) begin
            nxt_latch = lret_ff ? latch_saved_q : OUT_INIT;
        end else if (!running) begin
            nxt_latch = latch_ff;
        end else if (latch_reset) begin
            nxt_latch = OUT_INIT;
        end else if (latch_set) begin
            nxt_latch = OUT_ON;
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            latch_ff <= OUT_INIT;
        end else begin
            latch_ff <= nxt_latch;
        end
    end

    assign latch_q = latch_ff;

    // ========================================================================
    // Toggle relay element
    // ========================================================================
    // A trigger already high when the program starts becomes the previous sample
    // at the start scan, so it cannot toggle until it has gone low once.
    toggle_relay u_toggle (
        .clock         (clock),
        .arst_n        (arst_n),
        .set_in        (toggle_set & running),
        .reset_in      (toggle_reset & running),
        .trigger_in    (toggle_trigger & running),
        .prio_cfg      (prio_ff),
        .retain_cfg    (tret_ff),
        .retained_q    (toggle_saved_q),
        .restore_pulse (start_pulse),
        .q             (toggle_q)
    );

    // ========================================================================
    // Checks
    // ========================================================================
    latch_set_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && latch_set && !latch_reset) |=> latch_q)
        else $error("Latch did not set.");
    latch_both_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && latch_set && latch_reset) |=> !latch_q)
        else $error("Reset did not dominate set.");
    latch_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && !latch_set && !latch_reset) |=> $stable(latch_q))
        else $error("Latch changed with idle inputs.");
    latch_restore_a: assert property (@(posedge clock) disable iff (!arst_n)
        (start_pulse && lret_ff) |=> (latch_q == $past(latch_saved_q)))
        else $error("Latch retained state not restored.");
    cfg_frozen_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff) |=> ($stable(prio_ff) && $stable(lret_ff) && $stable(tret_ff)))
        else $error("Configuration changed while running.");
    cold_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        (start_pulse && !lret_ff && !tret_ff) |=> (!latch_q && !toggle_q))
        else $error("Outputs not low after non-retentive start.");

    // ========================================================================
    // Multi-scan sequences
    // ========================================================================
    // Latch set, latch clear and trigger-low sequences open on a scan whose inputs the elements really take.
    sequence latch_sets_s;
        running && run_prev_ff && latch_set && !latch_reset;
    endsequence
    sequence latch_clears_s;
        running && run_prev_ff && latch_reset;
    endsequence
    sequence latch_idle_s;
        running && !latch_set && !latch_reset;
    endsequence
    sequence trig_low_s;
        running && run_prev_ff && !toggle_trigger;
    endsequence
    sequence trig_free_rise_s;
        running && toggle_trigger && !toggle_set && !toggle_reset;
    endsequence
    sequence trig_forced_rise_s;
        running && toggle_trigger && (toggle_set || toggle_reset);
    endsequence
    sequence retained_start_s;
        !running ##1 (running && lret_ff && tret_ff);
    endsequence

    // ========================================================================
    // Multi-scan checks
    // ========================================================================
    latch_stays_on_a: assert property (@(posedge clock) disable iff (!arst_n)
        latch_sets_s ##1 latch_idle_s |=> latch_q)
        else $error("Latch lost its set state with idle inputs.");
    latch_stays_off_a: assert property (@(posedge clock) disable iff (!arst_n)
        latch_clears_s ##1 latch_idle_s |=> !latch_q)
        else $error("Latch came back on without a set.");
    toggle_edge_flip_a: assert property (@(posedge clock) disable iff (!arst_n)
        trig_low_s ##1 trig_free_rise_s |=> (toggle_q != $past(toggle_q)))
        else $error("Toggle output did not follow a free trigger edge.");
    toggle_edge_ignored_a: assert property (@(posedge clock) disable iff (!arst_n)
        trig_low_s ##1 trig_forced_rise_s |=> (toggle_q == ($past(toggle_set) &&
        (prio_ff == set_dominant || !$past(toggle_reset)))))
        else $error("Trigger edge acted while a forcing input was high.");
    toggle_idle_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && !toggle_trigger && !toggle_set && !toggle_reset)
        |=> $stable(toggle_q))
        else $error("Toggle output moved with no input active.");
    toggle_set_wins_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && toggle_set && toggle_reset && prio_ff == set_dominant)
        |=> toggle_q)
        else $error("Set-dominant toggle was cleared.");
    toggle_reset_wins_a: assert property (@(posedge clock) disable iff (!arst_n)
        (running && run_prev_ff && toggle_set && toggle_reset && prio_ff == reset_dominant)
        |=> !toggle_q)
        else $error("Reset-dominant toggle was set.");
    // While stopped the gated inputs are all low, so neither element may move.
    stopped_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
        !running |=> ($stable(latch_q) && $stable(toggle_q)))
        else $error("An output moved while the program was stopped.");
    cfg_capture_a: assert property (@(posedge clock) disable iff (!arst_n)
        !running |=> (prio_ff == $past(toggle_priority) && lret_ff == $past(latch_retain) &&
        tret_ff == $past(toggle_retain)))
        else $error("Configuration not taken while stopped.");
    latch_cold_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        (start_pulse && !lret_ff) |=> !latch_q)
        else $error("Latch not low after a non-retentive start.");
    toggle_cold_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        (start_pulse && !tret_ff) |=> !toggle_q)
        else $error("Toggle not low after a non-retentive start.");
    retained_start_a: assert property (@(posedge clock) disable iff (!arst_n)
        retained_start_s |=> (latch_q == $past(latch_saved_q) &&
        toggle_q == $past(toggle_saved_q)))
        else $error("Retained outputs not restored at start.");

endmodule
`default_nettype wire

// File: sim/nv_store.sv
// Partner model: non-volatile store keeping the relay outputs over power loss.
// Assumes the scan clock and that it is not cleared by the relay reset.
`timescale 1ns/10ps
`default_nettype none
module nv_store (
    input  wire logic clock,
    input  wire logic running,
    input  wire logic latch_q,
    input  wire logic toggle_q,
    output logic      latch_saved_q,
    output logic      toggle_saved_q
);
    // ========================================================================
    // Storage
    // ========================================================================
    // Captures only while running, so a stop before power loss keeps the state.
    initial begin
        latch_saved_q = 1'b0;
        toggle_saved_q = 1'b0;
    end
    always @(posedge clock) begin
        if (running) begin
            latch_saved_q  <= latch_q;
            toggle_saved_q <= toggle_q;
        end
    end
endmodule
`default_nettype wire

// File: sim/latch_and_toggle_relay_test.sv
// Testbench for the latch and toggle relay elements.
// Assumes the nv_store partner feeds the saved outputs back at start.
`timescale 1ns/10ps
`default_nettype none
module latch_and_toggle_relay_test;
    import relay_pkg::*;
    logic      clock = 1'b0;
    logic      arst_n = 1'b0;
    logic      running = 1'b0;
    logic      l_rt = 1'b0;
    logic      t_rt = 1'b0;
    priority_t prio = reset_dominant;
    logic [4:0] ins = 5'h00;
    logic      lq, tq, lsv, tsv;
    int        miscompares = 0;
    int        n_checks = 0;
    int        cycles = 0;

    latch_and_toggle_relay DUT (.clock(clock), .arst_n(arst_n), .running(running),
        .latch_set(ins[4]), .latch_reset(ins[3]), .latch_retain(l_rt),
        .latch_saved_q(lsv), .toggle_set(ins[2]), .toggle_reset(ins[1]),
        .toggle_trigger(ins[0]), .toggle_priority(prio), .toggle_retain(t_rt),
        .toggle_saved_q(tsv), .latch_q(lq), .toggle_q(tq));
    nv_store NV (.clock(clock), .running(running), .latch_q(lq), .toggle_q(tq),
        .latch_saved_q(lsv), .toggle_saved_q(tsv));

    initial begin
        forever #25 clock = ~clock;
    end
    // The scenarios take 33 scans; the ceiling leaves wide margin.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            miscompares++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic chk(input logic e, input logic g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Inputs: latch set, latch reset, toggle set, toggle reset, trigger.
    task automatic drv(input logic [4:0] v, input logic el, input logic et);
        ins = v;
        step(1);
        chk(el, lq);
        chk(et, tq);
    endtask
    // Power loss as a reset while stopped, then a start with the given config.
    task automatic restart(input logic rt, input priority_t p, input logic e);
        ins = 5'h00;
        running = 1'b0;
        step(1);
        arst_n = 1'b0;
        step(1);
        arst_n = 1'b1;
        l_rt = rt;
        t_rt = rt;
        prio = p;
        step(1);
        running = 1'b1;
        step(1);
        chk(e, lq);
        chk(e, tq);
    endtask

    task automatic latch_case();
        drv(5'h10, 1'b1, 1'b0);
        drv(5'h00, 1'b1, 1'b0);
        drv(5'h18, 1'b0, 1'b0);
        drv(5'h10, 1'b1, 1'b0);
        drv(5'h08, 1'b0, 1'b0);
    endtask
    task automatic toggle_case();
        drv(5'h01, 1'b0, 1'b1);
        drv(5'h00, 1'b0, 1'b1);
        drv(5'h01, 1'b0, 1'b0);
        drv(5'h02, 1'b0, 1'b0);
        drv(5'h03, 1'b0, 1'b0);
        drv(5'h04, 1'b0, 1'b1);
        drv(5'h05, 1'b0, 1'b1);
        drv(5'h06, 1'b0, 1'b0);
        drv(5'h14, 1'b1, 1'b1);
        drv(5'h00, 1'b1, 1'b1);
    endtask
    // While stopped every input is ignored and both outputs hold.
    task automatic stopped_case();
        running = 1'b0;
        drv(5'h0B, 1'b1, 1'b1);
        drv(5'h1F, 1'b1, 1'b1);
    endtask
    task automatic priority_case();
        drv(5'h06, 1'b1, 1'b1);
        prio = reset_dominant;
        drv(5'h06, 1'b1, 1'b1);
        drv(5'h02, 1'b1, 1'b0);
        drv(5'h14, 1'b1, 1'b1);
    endtask

    initial begin
        step(2);
        arst_n = 1'b1;
        step(1);
        running = 1'b1;
        step(1);
        chk(1'b0, lq);
        chk(1'b0, tq);
        latch_case();
        toggle_case();
        stopped_case();
        restart(1'b1, set_dominant, 1'b1);
        priority_case();
        restart(1'b0, reset_dominant, 1'b0);
        give_verdict();
    end
endmodule
`default_nettype wire
